//--- design/adcseq_top.sv
// adcseq_top: command-driven sequencer for the 8-bit housekeeping converter
// assumes the register port and the converter's digital side run on CLK_IN
`timescale 1ns/10ps
`include "adcseq_map.svh"
module adcseq_top (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire adcseq_pkg::adcseq_byte_t REG_ADDR_IN,
  input wire adcseq_pkg::adcseq_byte_t REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output adcseq_pkg::adcseq_byte_t REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  output logic ADC_START_OUT,
  output adcseq_pkg::adcseq_chan_t ADC_CHAN_OUT,
  output logic ADC_SUPPLY_HALF_OUT,
  input wire logic ADC_DONE_IN,
  input wire adcseq_pkg::adcseq_byte_t ADC_DATA_IN,
  output adcseq_pkg::adcseq_byte_t BURST_DATA_OUT,
  output adcseq_pkg::adcseq_chan_t BURST_CHAN_OUT,
  output logic BURST_VALID_OUT,
  output logic CONV_BUSY_OUT,
  output logic CONT_ACTIVE_OUT
);
  import adcseq_pkg::*;

  adcseq_state_e state;
  adcseq_chan_t cur_chan;
  logic cur_continuous;
  adcseq_byte_t command_reg;
  adcseq_byte_t housekeeping;
  logic done_flag;
  logic slot_tick;

  logic cmd_write;
  logic [1:0] cmd_mode;
  adcseq_chan_t cmd_chan;
  logic cmd_mode_ok;
  logic cmd_onehot;
  logic cmd_enabled;
  logic cmd_accept;
  logic cur_enabled;
  logic launch;
  logic store;
  logic flag_read;
  logic hk_write;
  adcseq_byte_t read_value;
  adcseq_byte_t result [`ADCSEQ_NUM_CHANNELS];
  logic [`ADCSEQ_NUM_CHANNELS-1:0] load;

  function automatic logic group_enabled(input adcseq_chan_t chan, input adcseq_byte_t hk);
    logic ok;
    ok = 1'b0;
    if ((chan & `ADCSEQ_CH_EXTERNAL_MASK) != 6'h00) begin
      ok = hk[`ADCSEQ_HK_EXTERNAL_BIT];
    end else if ((chan & `ADCSEQ_CH_INTERNAL_MASK) != 6'h00) begin
      ok = hk[`ADCSEQ_HK_INTERNAL_BIT];
    end
    return ok;
  endfunction

  adcseq_slot_tick u_slot_tick (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .tick_out(slot_tick)
  );

  // command decode
  assign cmd_write = REG_WR_IN && (REG_ADDR_IN == `ADCSEQ_ADDR_COMMAND);
  assign cmd_mode = REG_WDATA_IN[7:6];
  assign cmd_chan = REG_WDATA_IN[5:0];
  assign cmd_mode_ok = (cmd_mode == `ADCSEQ_MODE_SINGLE) || (cmd_mode == `ADCSEQ_MODE_CONTINUOUS);
  assign cmd_onehot = (cmd_chan != 6'h00) && ((cmd_chan & (cmd_chan - 6'h01)) == 6'h00);
  assign cmd_enabled = group_enabled(cmd_chan, housekeeping);
  // accepted in any state, so continuous runs beside transmit or receive activity elsewhere
  assign cmd_accept = cmd_write && cmd_mode_ok && cmd_onehot && cmd_enabled;
  assign hk_write = REG_WR_IN && (REG_ADDR_IN == `ADCSEQ_ADDR_HOUSEKEEPING);
  assign flag_read = REG_RD_IN && (REG_ADDR_IN == `ADCSEQ_ADDR_FLAG);

  assign cur_enabled = group_enabled(cur_chan, housekeeping);
  assign launch = (state == ST_WAIT_SLOT) && slot_tick && cur_enabled && !cmd_accept;
  // a result that lands as a new command arrives is still the old channel's valid sample
  assign store = (state == ST_CONVERT) && ADC_DONE_IN;

  // the raw command byte is kept even when refused, so the host can see what it last sent
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      command_reg <= 8'h00;
    end else if (cmd_write) begin
      command_reg <= REG_WDATA_IN;
    end
  end

  // both groups come out of reset enabled, so a fresh part converts without setup
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      housekeeping <= `ADCSEQ_HK_RESET;
    end else if (hk_write) begin
      housekeeping <= REG_WDATA_IN;
    end
  end

  // sequencer state
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state <= ST_IDLE;
    end else if (cmd_accept) begin
      state <= ST_WAIT_SLOT;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_WAIT_SLOT: begin
          // clearing the group enable stops a pending or repeating request
          if (!cur_enabled) begin
            state <= ST_IDLE;
          end else if (launch) begin
            state <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (ADC_DONE_IN) begin
            if (cur_continuous) begin
              state <= ST_WAIT_SLOT;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // kept after a single finishes, so the converter side still names the last channel
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cur_chan <= 6'h00;
    end else if (cmd_accept) begin
      cur_chan <= cmd_chan;
    end
  end

  // dropping the group enable also ends repetition; re-enabling alone does not restart it
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cur_continuous <= 1'b0;
    end else if (cmd_accept) begin
      cur_continuous <= (cmd_mode == `ADCSEQ_MODE_CONTINUOUS);
    end else if ((state == ST_WAIT_SLOT) && !cur_enabled) begin
      cur_continuous <= 1'b0;
    end
  end

  // converter control
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ADC_START_OUT <= 1'b0;
    end else begin
      ADC_START_OUT <= launch;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ADC_CHAN_OUT <= 6'h00;
    end else if (launch) begin
      ADC_CHAN_OUT <= cur_chan;
    end
  end

  // battery is sampled through the halving divider tap, never the raw supply
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ADC_SUPPLY_HALF_OUT <= 1'b0;
    end else if (launch) begin
      ADC_SUPPLY_HALF_OUT <= (cur_chan == `ADCSEQ_CH_SUPPLY);
    end
  end

  // result bank, one register per channel
  // host writes to the result addresses fall through the decode and change nothing
  generate
    for (genvar i = 0; i < `ADCSEQ_NUM_CHANNELS; i++) begin : g_result
      assign load[i] = store && cur_chan[i];
      adcseq_result_reg u_result (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .load_in(load[i]),
        .data_in(ADC_DATA_IN),
        .value_out(result[i])
      );
    end
  endgenerate

  // completion flag: a completion in the same cycle as the clearing read wins
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      done_flag <= 1'b0;
    end else if (store) begin
      done_flag <= 1'b1;
    end else if (flag_read) begin
      done_flag <= 1'b0;
    end
  end

  // register read mux
  // unmapped addresses read as zero, so probing a hole has no side effect
  always_comb begin
    read_value = 8'h00;
    case (REG_ADDR_IN)
      `ADCSEQ_ADDR_COMMAND: begin
        read_value = command_reg;
      end
      `ADCSEQ_ADDR_FLAG: begin
        read_value = 8'h00;
        read_value[`ADCSEQ_FLAG_DONE_BIT] = done_flag;
      end
      `ADCSEQ_ADDR_HOUSEKEEPING: begin
        read_value = housekeeping;
      end
      `ADCSEQ_ADDR_THERMAL: begin
        read_value = result[`ADCSEQ_IDX_THERMAL];
      end
      `ADCSEQ_ADDR_SUPPLY: begin
        read_value = result[`ADCSEQ_IDX_SUPPLY];
      end
      `ADCSEQ_ADDR_SIGNAL_LEVEL: begin
        read_value = result[`ADCSEQ_IDX_SIGNAL_LEVEL];
      end
      `ADCSEQ_ADDR_EXTERNAL_ONE: begin
        read_value = result[`ADCSEQ_IDX_EXTERNAL_ONE];
      end
      `ADCSEQ_ADDR_EXTERNAL_TWO: begin
        read_value = result[`ADCSEQ_IDX_EXTERNAL_TWO];
      end
      `ADCSEQ_ADDR_SYNTH_FILTER: begin
        read_value = result[`ADCSEQ_IDX_SYNTH_FILTER];
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= read_value;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
    end
  end

  // each fresh sample is also offered to the burst transmitter; no buffering, it must take it now
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      BURST_DATA_OUT <= 8'h00;
      BURST_CHAN_OUT <= 6'h00;
    end else if (store) begin
      BURST_DATA_OUT <= ADC_DATA_IN;
      BURST_CHAN_OUT <= cur_chan;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      BURST_VALID_OUT <= 1'b0;
    end else begin
      BURST_VALID_OUT <= store;
    end
  end

  // status levels, one cycle behind the state
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CONV_BUSY_OUT <= 1'b0;
    end else begin
      CONV_BUSY_OUT <= (state != ST_IDLE);
    end
  end

  // continuous is reported only while a request is live, never from a stale mode bit
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CONT_ACTIVE_OUT <= 1'b0;
    end else begin
      CONT_ACTIVE_OUT <= (state != ST_IDLE) && cur_continuous;
    end
  end
endmodule

//--- design/adcseq_map.svh
// adcseq_map.svh: register offsets, field positions, reset values and timing counts of the ADC sequencer
// assumes a 100 MHz system clock and an 8-bit register port on that same clock
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH

`define ADCSEQ_ADDR_COMMAND 8'h00
`define ADCSEQ_ADDR_FLAG 8'h01
`define ADCSEQ_ADDR_HOUSEKEEPING 8'h1B
`define ADCSEQ_ADDR_THERMAL 8'h34
`define ADCSEQ_ADDR_SUPPLY 8'h35
`define ADCSEQ_ADDR_SIGNAL_LEVEL 8'h36
`define ADCSEQ_ADDR_EXTERNAL_ONE 8'h37
`define ADCSEQ_ADDR_EXTERNAL_TWO 8'h38
`define ADCSEQ_ADDR_SYNTH_FILTER 8'h39

`define ADCSEQ_MODE_SINGLE 2'h1
`define ADCSEQ_MODE_CONTINUOUS 2'h3

`define ADCSEQ_CH_EXTERNAL_ONE 6'h01
`define ADCSEQ_CH_EXTERNAL_TWO 6'h02
`define ADCSEQ_CH_THERMAL 6'h04
`define ADCSEQ_CH_SUPPLY 6'h08
`define ADCSEQ_CH_SIGNAL_LEVEL 6'h10
`define ADCSEQ_CH_SYNTH_FILTER 6'h20
`define ADCSEQ_CH_EXTERNAL_MASK 6'h03
`define ADCSEQ_CH_INTERNAL_MASK 6'h3C

`define ADCSEQ_IDX_EXTERNAL_ONE 0
`define ADCSEQ_IDX_EXTERNAL_TWO 1
`define ADCSEQ_IDX_THERMAL 2
`define ADCSEQ_IDX_SUPPLY 3
`define ADCSEQ_IDX_SIGNAL_LEVEL 4
`define ADCSEQ_IDX_SYNTH_FILTER 5
`define ADCSEQ_NUM_CHANNELS 6

`define ADCSEQ_FLAG_DONE_BIT 0
`define ADCSEQ_HK_INTERNAL_BIT 4
`define ADCSEQ_HK_EXTERNAL_BIT 3
`define ADCSEQ_HK_RESET 8'h18
`define ADCSEQ_RESULT_RESET 8'h00

`define ADCSEQ_CLK_HZ 100000000
`define ADCSEQ_MAX_SAMPLE_HZ 128000
`define ADCSEQ_SLOT_CYCLES ((`ADCSEQ_CLK_HZ + `ADCSEQ_MAX_SAMPLE_HZ - 1) / `ADCSEQ_MAX_SAMPLE_HZ)
`define ADCSEQ_SLOT_W 10

`endif

//--- design/adcseq_pkg.sv
// adcseq_pkg: types shared by the ADC sequencer modules
// assumes nothing beyond the map header for its numbers
package adcseq_pkg;
  typedef logic [7:0] adcseq_byte_t;
  typedef logic [5:0] adcseq_chan_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_SLOT,
    ST_CONVERT
  } adcseq_state_e;
endpackage

//--- design/adcseq_slot_tick.sv
// adcseq_slot_tick: free-running divider giving a one-cycle start slot enable
// assumes one system clock; the slot period bounds the sample rate
`timescale 1ns/10ps
`include "adcseq_map.svh"
module adcseq_slot_tick (
  input wire logic clk_in,
  input wire logic rstn_in,
  output logic tick_out
);
  logic [`ADCSEQ_SLOT_W-1:0] count;
  logic at_end;

  assign at_end = (count == `ADCSEQ_SLOT_W'(`ADCSEQ_SLOT_CYCLES - 1));

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else if (at_end) begin
      count <= '0;
    end else begin
      count <= count + `ADCSEQ_SLOT_W'(1);
    end
  end

  // one start per slot keeps throughput at or under the converter maximum
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= at_end;
    end
  end
endmodule

//--- design/adcseq_result_reg.sv
// adcseq_result_reg: one read-only result byte, loaded only by a finished conversion
// assumes the load strobe is already qualified by the channel
`timescale 1ns/10ps
`include "adcseq_map.svh"
module adcseq_result_reg (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire adcseq_pkg::adcseq_byte_t data_in,
  output adcseq_pkg::adcseq_byte_t value_out
);
  import adcseq_pkg::*;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      value_out <= `ADCSEQ_RESULT_RESET;
    end else if (load_in) begin
      value_out <= data_in;
    end
  end
endmodule

//--- test/adcseq_checker.sv
// adcseq_checker: port assertions for adcseq_top
// assumes a converter that answers three cycles after start
`timescale 1ns/10ps
module adcseq_checker (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic REG_RD_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RVALID_OUT,
  input wire logic ADC_START_OUT,
  input wire adcseq_pkg::adcseq_chan_t ADC_CHAN_OUT,
  input wire logic ADC_SUPPLY_HALF_OUT,
  input wire logic ADC_DONE_IN,
  input wire adcseq_pkg::adcseq_byte_t ADC_DATA_IN,
  input wire adcseq_pkg::adcseq_byte_t BURST_DATA_OUT,
  input wire adcseq_pkg::adcseq_chan_t BURST_CHAN_OUT,
  input wire logic BURST_VALID_OUT,
  input wire logic CONT_ACTIVE_OUT
);
  import adcseq_pkg::*;
  logic [9:0] gap;
  logic seen;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // saturating count of cycles since the last start
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      gap <= 10'h000;
      seen <= 1'b0;
    end else if (ADC_START_OUT) begin
      gap <= 10'h000;
      seen <= 1'b1;
    end else if (gap != 10'h3FF) begin
      gap <= gap + 10'h001;
    end
  end
  sequence s_launch;
    (ADC_START_OUT && !REG_WR_IN) ##1 (!ADC_DONE_IN && !REG_WR_IN) [*2] ##1 ADC_DONE_IN;
  endsequence
  chk_read_answer: assert property (
    REG_RD_IN |=> REG_RVALID_OUT) else $error("read not answered");
  chk_done_burst: assert property (
    s_launch |=> BURST_VALID_OUT && BURST_DATA_OUT == $past(ADC_DATA_IN) && BURST_CHAN_OUT == ADC_CHAN_OUT)
    else $error("sample not stored");
  chk_burst_cause: assert property (
    BURST_VALID_OUT |-> $past(ADC_DONE_IN)) else $error("sample without conversion");
  chk_start_gap: assert property (
    ADC_START_OUT && seen |-> gap >= 10'h30D) else $error("starts too close");
  chk_chan_onehot: assert property (
    ADC_START_OUT |-> $onehot(ADC_CHAN_OUT)) else $error("channel not one-hot");
  chk_supply_tap: assert property (
    ADC_START_OUT |-> ADC_SUPPLY_HALF_OUT == (ADC_CHAN_OUT == 6'h08)) else $error("divider tap wrong");
  chk_chan_hold: assert property (
    $changed(ADC_CHAN_OUT) |-> ADC_START_OUT) else $error("channel moved without start");
  chk_cont_repeat: assert property (
    BURST_VALID_OUT && CONT_ACTIVE_OUT |-> ##[1:790] (ADC_START_OUT || REG_WR_IN))
    else $error("continuous mode stalled");
endmodule
bind adcseq_top adcseq_checker chk_u (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .REG_RD_IN(REG_RD_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RVALID_OUT(REG_RVALID_OUT), .ADC_START_OUT(ADC_START_OUT),
  .ADC_CHAN_OUT(ADC_CHAN_OUT), .ADC_SUPPLY_HALF_OUT(ADC_SUPPLY_HALF_OUT), .ADC_DONE_IN(ADC_DONE_IN),
  .ADC_DATA_IN(ADC_DATA_IN), .BURST_DATA_OUT(BURST_DATA_OUT), .BURST_CHAN_OUT(BURST_CHAN_OUT),
  .BURST_VALID_OUT(BURST_VALID_OUT), .CONT_ACTIVE_OUT(CONT_ACTIVE_OUT));

//--- test/adcseq_conv_model.sv
// adcseq_conv_model: converter model, done three cycles after start
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/10ps
module adcseq_conv_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic half_in,
  input wire adcseq_pkg::adcseq_byte_t level_in,
  output logic done_out,
  output adcseq_pkg::adcseq_byte_t data_out
);
  import adcseq_pkg::*;
  logic [2:0] pipe;
  adcseq_byte_t held;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pipe <= 3'h0;
      held <= 8'h00;
    end else begin
      pipe <= {pipe[1:0], start_in};
      if (start_in) begin
        held <= half_in ? {1'b0, level_in[7:1]} : level_in;
      end
    end
  end
  assign done_out = pipe[2];
  // outside the done cycle the bus shows garbage so late sampling fails
  assign data_out = done_out ? held : ~held;
endmodule

//--- test/testbench.sv
// testbench: drives adcseq_top registers, checks reads and burst samples
// assumes adcseq_conv_model as the converter
`timescale 1ns/10ps
`include "adcseq_map.svh"
module testbench;
  import adcseq_pkg::*;
  logic CLK_IN, RSTN_IN, REG_WR_IN, REG_RD_IN, REG_RVALID_OUT, ADC_START_OUT, ADC_SUPPLY_HALF_OUT;
  logic ADC_DONE_IN, BURST_VALID_OUT, CONV_BUSY_OUT, CONT_ACTIVE_OUT;
  adcseq_byte_t REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, ADC_DATA_IN, BURST_DATA_OUT, level, exp_v;
  adcseq_chan_t ADC_CHAN_OUT, BURST_CHAN_OUT;
  adcseq_byte_t rd_q[$];
  logic [13:0] bq[$];
  adcseq_byte_t res[6];
  adcseq_chan_t chans[6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  adcseq_byte_t addrs[6] = '{8'h37, 8'h38, 8'h34, 8'h35, 8'h36, 8'h39};
  int n_mismatch = 0, compares = 0, n_burst = 0, k, nb;
  adcseq_top dut_u (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT), .ADC_START_OUT(ADC_START_OUT),
    .ADC_CHAN_OUT(ADC_CHAN_OUT), .ADC_SUPPLY_HALF_OUT(ADC_SUPPLY_HALF_OUT), .ADC_DONE_IN(ADC_DONE_IN),
    .ADC_DATA_IN(ADC_DATA_IN), .BURST_DATA_OUT(BURST_DATA_OUT), .BURST_CHAN_OUT(BURST_CHAN_OUT),
    .BURST_VALID_OUT(BURST_VALID_OUT), .CONV_BUSY_OUT(CONV_BUSY_OUT), .CONT_ACTIVE_OUT(CONT_ACTIVE_OUT));
  adcseq_conv_model conv_u (.clk_in(CLK_IN), .rstn_in(RSTN_IN), .start_in(ADC_START_OUT),
    .half_in(ADC_SUPPLY_HALF_OUT), .level_in(level), .done_out(ADC_DONE_IN), .data_out(ADC_DATA_IN));
  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one access; a read leaves its expected byte for the monitor
  task automatic acc(input int w, input adcseq_byte_t a, input adcseq_byte_t d);
    if (w == 0) rd_q.push_back(d);
    REG_ADDR_IN = a;
    REG_WDATA_IN = d;
    REG_WR_IN = (w != 0);
    REG_RD_IN = (w == 0);
    @(negedge CLK_IN);
    REG_WR_IN = 1'b0;
    REG_RD_IN = 1'b0;
    @(negedge CLK_IN);
  endtask
  // n == 0 waits for idle, else until n samples were seen
  task automatic settle(input int n);
    int i = 0;
    repeat (2) @(negedge CLK_IN);
    while ((n == 0 ? CONV_BUSY_OUT !== 1'b0 : n_burst < n) && i < 4000) begin
      @(negedge CLK_IN);
      i++;
    end
    if (i == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  always @(negedge CLK_IN) begin
    if (REG_RVALID_OUT === 1'b1) check({6'h00, REG_RDATA_OUT}, {6'h00, (rd_q.size() ? rd_q.pop_front() : 8'hXX)});
    if (BURST_VALID_OUT === 1'b1) begin
      n_burst++;
      check({BURST_CHAN_OUT, BURST_DATA_OUT}, bq.size() ? bq.pop_front() : {14{1'bX}});
    end
  end
  initial begin
    RSTN_IN = 1'b0;
    REG_WR_IN = 1'b0;
    REG_RD_IN = 1'b0;
    REG_ADDR_IN = 8'h00;
    REG_WDATA_IN = 8'h00;
    level = 8'h00;
    void'($urandom(14));
    repeat (6) @(negedge CLK_IN);
    RSTN_IN = 1'b1;
    @(negedge CLK_IN);
    acc(0, `ADCSEQ_ADDR_HOUSEKEEPING, 8'h18);
    acc(0, `ADCSEQ_ADDR_THERMAL, 8'h00);
    acc(0, 8'h50, 8'h00);
    for (k = 0; k < 6; k++) begin
      level = 8'($urandom);
      exp_v = (k == 3) ? level >> 1 : level;
      res[k] = exp_v;
      bq.push_back({chans[k], exp_v});
      acc(1, `ADCSEQ_ADDR_COMMAND, {2'b01, chans[k]});
      settle(0);
      acc(0, addrs[k], exp_v);
      acc(0, `ADCSEQ_ADDR_FLAG, 8'h01);
      acc(0, `ADCSEQ_ADDR_FLAG, 8'h00);
    end
    for (k = 0; k < 6; k++) acc(0, addrs[k], res[k]);
    acc(1, `ADCSEQ_ADDR_COMMAND, 8'h81);
    check({13'h0000, CONV_BUSY_OUT}, 14'h0000);
    acc(1, `ADCSEQ_ADDR_HOUSEKEEPING, 8'h10);
    acc(1, `ADCSEQ_ADDR_COMMAND, 8'h41);
    check({13'h0000, CONV_BUSY_OUT}, 14'h0000);
    acc(1, `ADCSEQ_ADDR_HOUSEKEEPING, 8'h18);
    level = 8'($urandom);
    exp_v = level >> 1;
    repeat (3) bq.push_back({`ADCSEQ_CH_SUPPLY, exp_v});
    nb = n_burst + 3;
    acc(1, `ADCSEQ_ADDR_COMMAND, 8'hC8);
    check({13'h0000, CONT_ACTIVE_OUT}, 14'h0001);
    settle(nb);
    acc(0, `ADCSEQ_ADDR_SUPPLY, exp_v);
    level = 8'($urandom);
    bq.push_back({`ADCSEQ_CH_THERMAL, level});
    acc(1, `ADCSEQ_ADDR_COMMAND, 8'h44);
    settle(0);
    check({13'h0000, CONT_ACTIVE_OUT}, 14'h0000);
    acc(0, `ADCSEQ_ADDR_THERMAL, level);
    acc(0, `ADCSEQ_ADDR_COMMAND, 8'h44);
    check(14'(bq.size()), 14'h0000);
    print_verdict();
  end
endmodule
